/* shared/eacm_pkg.sv */
// Constants and register map of the IPv4 entry matcher
`default_nettype none
package eacm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_VALS = 8'h04;
    localparam logic [7:0] OFS_SRC_ADDR = 8'h08;
    localparam logic [7:0] OFS_SRC_MASK = 8'h0c;
    localparam logic [7:0] OFS_DST_ADDR = 8'h10;
    localparam logic [7:0] OFS_DST_MASK = 8'h14;
    localparam logic [7:0] OFS_HIT_CNT = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    // Control register fields
    localparam int CTL_IPV4 = 0;
    localparam int CTL_PROTO = 1;
    localparam int CTL_TTL = 4;
    localparam int CTL_FRAG = 6;
    localparam int CTL_OPT = 8;
    localparam int CTL_SRC = 10;
    localparam int CTL_DST = 12;
    localparam int CTL_ITYPE = 14;
    localparam int CTL_ICODE = 15;
    localparam int CTL_W = 16;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    // Value register fields
    localparam int VAL_PROTO = 0;
    localparam int VAL_ITYPE = 8;
    localparam int VAL_ICODE = 16;
    localparam logic [23:0] VALS_RST = 24'h000000;
    localparam logic [31:0] ADDR_RST = 32'h00000000;
    localparam logic [31:0] MASK_RST = 32'hffffffff;
    // Protocol criterion codes
    localparam logic [2:0] PR_ANY = 3'h0;
    localparam logic [2:0] PR_SPEC = 3'h1;
    localparam logic [2:0] PR_ICMP = 3'h2;
    localparam logic [2:0] PR_UDP = 3'h3;
    localparam logic [2:0] PR_TCP = 3'h4;
    // Tri-state and address criterion codes
    localparam logic [1:0] TRI_ANY = 2'h0;
    localparam logic [1:0] TRI_NO = 2'h1;
    localparam logic [1:0] TRI_YES = 2'h2;
    localparam logic [1:0] AD_ANY = 2'h0;
    localparam logic [1:0] AD_HOST = 2'h1;
    localparam logic [1:0] AD_NET = 2'h2;
    // IPv4 protocol numbers and the AHB-Lite NONSEQ transfer code
    localparam logic [7:0] IPP_ICMP = 8'h01;
    localparam logic [7:0] IPP_TCP = 8'h06;
    localparam logic [7:0] IPP_UDP = 8'h11;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : eacm_pkg
`default_nettype wire

/* shared/eacm_match_if.sv */
// Configuration and parsed header carried to the match core
`timescale 1ns/100ps
`default_nettype none
interface eacm_match_if;
    logic ipv4_sel;
    logic [2:0] proto_mode;
    logic [1:0] ttl_mode, frag_mode, opt_mode, src_mode, dst_mode;
    logic itype_spec, icode_spec;
    logic [7:0] proto_val, itype_val, icode_val;
    logic [31:0] src_addr, src_mask, dst_addr, dst_mask;
    logic [7:0] f_proto, f_ttl, f_itype, f_icode;
    logic f_more_fragments_bit, f_options;
    logic [12:0] f_fragment_offset_field;
    logic [31:0] f_source_ip_address, f_destination_ip_address;
    logic hit;
    modport cfg (output ipv4_sel, proto_mode, ttl_mode, frag_mode, opt_mode, src_mode,
        dst_mode, itype_spec, icode_spec, proto_val, itype_val, icode_val, src_addr,
        src_mask, dst_addr, dst_mask, f_proto, f_ttl, f_itype, f_icode,
        f_more_fragments_bit, f_options, f_fragment_offset_field, f_source_ip_address,
        f_destination_ip_address, input hit);
    modport core (input ipv4_sel, proto_mode, ttl_mode, frag_mode, opt_mode, src_mode,
        dst_mode, itype_spec, icode_spec, proto_val, itype_val, icode_val, src_addr,
        src_mask, dst_addr, dst_mask, f_proto, f_ttl, f_itype, f_icode,
        f_more_fragments_bit, f_options, f_fragment_offset_field, f_source_ip_address,
        f_destination_ip_address, output hit);
endinterface : eacm_match_if
`default_nettype wire

/* rtl/eacm_match_core.sv */
// Combinational match decision of one access control entry
`timescale 1ns/100ps
`default_nettype none
module eacm_match_core
    import eacm_pkg::*;
(
    eacm_match_if.core m
);
    // Code 3 of a tri-state field is unused and behaves as don't-care
    function automatic logic tri_ok(input logic [1:0] sel, input logic present);
        unique case (sel)
            TRI_NO: tri_ok = !present;
            TRI_YES: tri_ok = present;
            default: tri_ok = 1'b1;
        endcase
    endfunction : tri_ok

    function automatic logic addr_ok(input logic [1:0] mode, input logic [31:0] fa,
        input logic [31:0] ca, input logic [31:0] mk);
        unique case (mode)
            AD_HOST: addr_ok = (fa == ca);
            AD_NET: addr_ok = ((fa ^ ca) & mk) == 32'h00000000;
            default: addr_ok = 1'b1;
        endcase
    endfunction : addr_ok

    function automatic logic byte_ok(input logic spec, input logic [7:0] fv,
        input logic [7:0] cv);
        byte_ok = !spec || (fv == cv);
    endfunction : byte_ok

    logic proto_ok, ttl_ok, frag_ok, opt_ok, src_ok, dst_ok, icmp_ok;

    always_comb begin
        unique case (m.proto_mode)
            PR_SPEC: proto_ok = (m.f_proto == m.proto_val);
            PR_ICMP: proto_ok = (m.f_proto == IPP_ICMP);
            PR_UDP: proto_ok = (m.f_proto == IPP_UDP);
            PR_TCP: proto_ok = (m.f_proto == IPP_TCP);
            default: proto_ok = 1'b1;
        endcase
    end

    // Zero setting is "no TTL present", non-zero is "TTL present"
    assign ttl_ok = tri_ok(m.ttl_mode, m.f_ttl != 8'h00);
    assign frag_ok = tri_ok(m.frag_mode, m.f_more_fragments_bit ||
        (m.f_fragment_offset_field != 13'h0000));
    assign opt_ok = tri_ok(m.opt_mode, m.f_options);
    assign src_ok = addr_ok(m.src_mode, m.f_source_ip_address, m.src_addr, m.src_mask);
    assign dst_ok = addr_ok(m.dst_mode, m.f_destination_ip_address, m.dst_addr,
        m.dst_mask);
    assign icmp_ok = (m.proto_mode != PR_ICMP) ||
        (byte_ok(m.itype_spec, m.f_itype, m.itype_val) &&
        byte_ok(m.icode_spec, m.f_icode, m.icode_val));
    // Other frame types leave every IPv4 criterion out of the decision
    assign m.hit = !m.ipv4_sel || (proto_ok && ttl_ok && frag_ok && opt_ok &&
        src_ok && dst_ok && icmp_ok);
endmodule : eacm_match_core
`default_nettype wire

/* rtl/eacm_ipv4_entry.sv */
// IPv4 access control entry matcher with AHB-Lite configuration slave
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module eacm_ipv4_entry
    import eacm_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Parsed IPv4 header from the frame pipeline
    input wire logic frm_valid,
    input wire logic [7:0] frm_protocol,
    input wire logic [7:0] frm_ttl,
    input wire logic frm_more_fragments_bit,
    input wire logic [12:0] frm_fragment_offset_field,
    input wire logic frm_options,
    input wire logic [31:0] frm_source_ip_address,
    input wire logic [31:0] frm_destination_ip_address,
    input wire logic [7:0] frm_icmp_type,
    input wire logic [7:0] frm_icmp_code,
    // Match result
    output logic hit_valid,
    output logic hit
);
    if (CNT_W < 1 || CNT_W > 32) begin : g_chk
        $error("CNT_W must lie between 1 and 32");
    end

    logic [15:0] ctrl_ff;
    logic [23:0] vals_ff;
    logic [31:0] src_addr_ff, src_mask_ff, dst_addr_ff, dst_mask_ff;
    logic [CNT_W-1:0] hit_cnt_ff;
    logic dphase_ff, wr_ff, hreadyout_ff, hit_valid_ff, hit_ff;
    logic [7:0] addr_ff;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic accept, do_write;

    eacm_match_if mif ();

    // Register fields steer the match core directly
    assign mif.ipv4_sel = ctrl_ff[CTL_IPV4];
    assign mif.proto_mode = ctrl_ff[CTL_PROTO +: 3];
    assign mif.ttl_mode = ctrl_ff[CTL_TTL +: 2];
    assign mif.frag_mode = ctrl_ff[CTL_FRAG +: 2];
    assign mif.opt_mode = ctrl_ff[CTL_OPT +: 2];
    assign mif.src_mode = ctrl_ff[CTL_SRC +: 2];
    assign mif.dst_mode = ctrl_ff[CTL_DST +: 2];
    assign mif.itype_spec = ctrl_ff[CTL_ITYPE];
    assign mif.icode_spec = ctrl_ff[CTL_ICODE];
    assign mif.proto_val = vals_ff[VAL_PROTO +: 8];
    assign mif.itype_val = vals_ff[VAL_ITYPE +: 8];
    assign mif.icode_val = vals_ff[VAL_ICODE +: 8];
    assign mif.src_addr = src_addr_ff;
    assign mif.src_mask = src_mask_ff;
    assign mif.dst_addr = dst_addr_ff;
    assign mif.dst_mask = dst_mask_ff;
    assign mif.f_proto = frm_protocol;
    assign mif.f_ttl = frm_ttl;
    assign mif.f_itype = frm_icmp_type;
    assign mif.f_icode = frm_icmp_code;
    assign mif.f_more_fragments_bit = frm_more_fragments_bit;
    assign mif.f_options = frm_options;
    assign mif.f_fragment_offset_field = frm_fragment_offset_field;
    assign mif.f_source_ip_address = frm_source_ip_address;
    assign mif.f_destination_ip_address = frm_destination_ip_address;

    eacm_match_core u_core (
        .m (mif.core)
    );

    // Bus slave: every transfer takes one wait state, so a read always
    // sees the result of the write before it without forwarding paths
    assign accept = hsel && htrans == HTRANS_NONSEQ && hready;
    assign do_write = dphase_ff && wr_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dphase_ff <= 1'b0;
            wr_ff <= 1'b0;
            addr_ff <= 8'h00;
        end else if (accept) begin
            dphase_ff <= 1'b1;
            wr_ff <= hwrite;
            addr_ff <= {haddr[7:2], 2'b00};
        end else begin
            dphase_ff <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
        end else begin
            hreadyout_ff <= !accept;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= CTRL_RST;
            vals_ff <= VALS_RST;
            src_addr_ff <= ADDR_RST;
            src_mask_ff <= MASK_RST;
            dst_addr_ff <= ADDR_RST;
            dst_mask_ff <= MASK_RST;
        end else if (do_write) begin
            unique case (addr_ff)
                OFS_CTRL: ctrl_ff <= hwdata[CTL_W-1:0];
                OFS_VALS: vals_ff <= hwdata[23:0];
                OFS_SRC_ADDR: src_addr_ff <= hwdata;
                OFS_SRC_MASK: src_mask_ff <= hwdata;
                OFS_DST_ADDR: dst_addr_ff <= hwdata;
                OFS_DST_MASK: dst_mask_ff <= hwdata;
                default: ;
            endcase
        end
    end

    // Unmapped offsets read as zero and ignore writes; response is OKAY
    always_comb begin
        nxt_hrdata = 32'h00000000;
        unique case (addr_ff)
            OFS_CTRL: nxt_hrdata = {16'h0000, ctrl_ff};
            OFS_VALS: nxt_hrdata = {8'h00, vals_ff};
            OFS_SRC_ADDR: nxt_hrdata = src_addr_ff;
            OFS_SRC_MASK: nxt_hrdata = src_mask_ff;
            OFS_DST_ADDR: nxt_hrdata = dst_addr_ff;
            OFS_DST_MASK: nxt_hrdata = dst_mask_ff;
            OFS_HIT_CNT: nxt_hrdata = 32'(hit_cnt_ff);
            OFS_STATUS: nxt_hrdata = {30'h0, hit_valid_ff, hit_ff};
            default: nxt_hrdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h00000000;
        end else if (dphase_ff && !wr_ff) begin
            hrdata_ff <= nxt_hrdata;
        end
    end

    // Match result, registered one cycle after the header
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hit_valid_ff <= 1'b0;
            hit_ff <= 1'b0;
        end else begin
            hit_valid_ff <= frm_valid;
            hit_ff <= frm_valid && mif.hit;
        end
    end

    // Hit counter, cleared by a write to OFS_HIT_CNT; a hit in the same cycle still counts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hit_cnt_ff <= '0;
        end else if (hit_valid_ff && hit_ff) begin
            if (do_write && addr_ff == OFS_HIT_CNT) begin
                hit_cnt_ff <= CNT_W'(1);
            end else begin
                hit_cnt_ff <= hit_cnt_ff + CNT_W'(1);
            end
        end else if (do_write && addr_ff == OFS_HIT_CNT) begin
            hit_cnt_ff <= '0;
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign hit_valid = hit_valid_ff;
    assign hit = hit_ff;

    // Checks on the decision and the bus slave, taken from the registers, the header and the bus
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic ipv4_on;
    logic [2:0] pmode;
    assign ipv4_on = ctrl_ff[CTL_IPV4];
    assign pmode = ctrl_ff[CTL_PROTO +: 3];

    not_ipv4_a: assert property (frm_valid && !ipv4_on |=> hit_valid && hit)
        else $error("entry without IPv4 type must hit every frame");
    any_all_a: assert property (frm_valid && ipv4_on && ctrl_ff[13:1] == 13'h0000
        |=> hit) else $error("all don't-care entry missed a frame");
    proto_spec_a: assert property (frm_valid && ipv4_on && pmode == PR_SPEC &&
        frm_protocol != vals_ff[VAL_PROTO +: 8] |=> hit_valid && !hit)
        else $error("specific protocol mismatch produced a hit");
    proto_icmp_a: assert property (frm_valid && ipv4_on && pmode == PR_ICMP &&
        frm_protocol != IPP_ICMP |=> !hit) else $error("non-ICMP frame hit ICMP entry");
    proto_udp_a: assert property (frm_valid && ipv4_on && pmode == PR_UDP &&
        frm_protocol != IPP_UDP |=> !hit) else $error("non-UDP frame hit UDP entry");
    proto_tcp_a: assert property (frm_valid && ipv4_on && pmode == PR_TCP &&
        frm_protocol != IPP_TCP |=> !hit) else $error("non-TCP frame hit TCP entry");
    proto_any_a: assert property (frm_valid && ipv4_on && pmode == PR_ANY &&
        ctrl_ff[13:4] == 10'h000 |=> hit) else $error("protocol don't-care rejected frame");
    ttl_zero_a: assert property (frm_valid && ipv4_on &&
        ctrl_ff[CTL_TTL +: 2] == TRI_NO && frm_ttl != 8'h00 |=> !hit)
        else $error("TTL zero setting passed a live frame");
    ttl_nz_a: assert property (frm_valid && ipv4_on &&
        ctrl_ff[CTL_TTL +: 2] == TRI_YES && frm_ttl == 8'h00 |=> !hit)
        else $error("TTL non-zero setting passed a dead frame");
    frag_no_a: assert property (frm_valid && ipv4_on && ctrl_ff[CTL_FRAG +: 2] == TRI_NO
        && (frm_more_fragments_bit || frm_fragment_offset_field != 13'h0000) |=> !hit)
        else $error("fragment No setting passed a fragment");
    frag_yes_a: assert property (frm_valid && ipv4_on && ctrl_ff[CTL_FRAG +: 2] == TRI_YES
        && !frm_more_fragments_bit && frm_fragment_offset_field == 13'h0000 |=> !hit)
        else $error("fragment Yes setting passed a whole frame");
    opt_check_a: assert property (frm_valid && ipv4_on &&
        ((ctrl_ff[CTL_OPT +: 2] == TRI_NO && frm_options) ||
        (ctrl_ff[CTL_OPT +: 2] == TRI_YES && !frm_options)) |=> !hit)
        else $error("options setting not honoured");
    src_host_a: assert property (frm_valid && ipv4_on && ctrl_ff[CTL_SRC +: 2] == AD_HOST
        && frm_source_ip_address != src_addr_ff |=> !hit)
        else $error("source host mismatch produced a hit");
    src_net_a: assert property (frm_valid && ipv4_on && ctrl_ff[CTL_SRC +: 2] == AD_NET &&
        ((frm_source_ip_address ^ src_addr_ff) & src_mask_ff) != 32'h00000000 |=> !hit)
        else $error("source network mismatch produced a hit");
    dst_host_a: assert property (frm_valid && ipv4_on && ctrl_ff[CTL_DST +: 2] == AD_HOST
        && frm_destination_ip_address != dst_addr_ff |=> !hit)
        else $error("destination host mismatch produced a hit");
    dst_net_a: assert property (frm_valid && ipv4_on && ctrl_ff[CTL_DST +: 2] == AD_NET &&
        ((frm_destination_ip_address ^ dst_addr_ff) & dst_mask_ff) != 32'h00000000 |=> !hit)
        else $error("destination network mismatch produced a hit");
    icmp_type_a: assert property (frm_valid && ipv4_on && pmode == PR_ICMP &&
        ctrl_ff[CTL_ITYPE] && frm_icmp_type != vals_ff[VAL_ITYPE +: 8] |=> !hit)
        else $error("ICMP type mismatch produced a hit");
    icmp_code_a: assert property (frm_valid && ipv4_on && pmode == PR_ICMP &&
        ctrl_ff[CTL_ICODE] && frm_icmp_code != vals_ff[VAL_ICODE +: 8] |=> !hit)
        else $error("ICMP code mismatch produced a hit");
    icmp_ignored_a: assert property (frm_valid && ipv4_on && pmode == PR_UDP &&
        ctrl_ff[CTL_ITYPE] && frm_protocol == IPP_UDP && ctrl_ff[13:4] == 10'h000
        |=> hit) else $error("ICMP criteria affected a UDP entry");
    no_frame_a: assert property (!frm_valid |=> !hit_valid && !hit)
        else $error("hit without a frame");
    bus_wait_a: assert property (accept |=> !hreadyout ##1 hreadyout)
        else $error("transfer not answered after one wait state");
    rd_back_a: assert property (accept && hwrite && haddr[7:0] == OFS_SRC_MASK ##[2:3]
        accept && !hwrite && haddr[7:0] == OFS_SRC_MASK |-> ##2 hrdata == $past(src_mask_ff))
        else $error("read back of source mask wrong");

    icmp_hit_c: cover property (frm_valid && ipv4_on && pmode == PR_ICMP ##1 hit);
    net_hit_c: cover property (frm_valid && ipv4_on && ctrl_ff[CTL_SRC +: 2] == AD_NET ##1 hit);
    miss_c: cover property (frm_valid && ipv4_on ##1 hit_valid && !hit);
    clr_c: cover property (do_write && addr_ff == OFS_HIT_CNT && hit_valid_ff && hit_ff);
endmodule : eacm_ipv4_entry
`default_nettype wire

/* tb/eacm_frame_src.sv */
// Frame pipeline model that presents one parsed IPv4 header per call
`timescale 1ns/100ps
`default_nettype none
module eacm_frame_src (
    // Clock
    input wire logic hclk,
    // Parsed header toward the entry
    output logic frm_valid,
    output logic [7:0] frm_protocol,
    output logic [7:0] frm_ttl,
    output logic frm_more_fragments_bit,
    output logic [12:0] frm_fragment_offset_field,
    output logic frm_options,
    output logic [31:0] frm_source_ip_address,
    output logic [31:0] frm_destination_ip_address,
    output logic [7:0] frm_icmp_type,
    output logic [7:0] frm_icmp_code
);
    logic [110:0] fld;
    assign {frm_protocol, frm_ttl, frm_more_fragments_bit, frm_fragment_offset_field,
        frm_options, frm_source_ip_address, frm_destination_ip_address, frm_icmp_type,
        frm_icmp_code} = fld;
    initial begin
        frm_valid = 1'b0;
        fld = '0;
    end
    // Entered just after a rising edge; fields are inverted once the pulse ends
    // so that a stale header can never pass for a held one
    task automatic send(input logic [110:0] f);
        frm_valid <= 1'b1;
        fld <= f;
        @(posedge hclk);
        frm_valid <= 1'b0;
        fld <= ~f;
    endtask : send
endmodule : eacm_frame_src
`default_nettype wire

/* tb/eacm_ipv4_entry_tb_top.sv */
// Self-checking bench: AHB-Lite register access and IPv4 entry match decisions
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("ERROR at %0t: got %h expected %h", $time, got, exp); end end
module eacm_ipv4_entry_tb_top;
    import eacm_pkg::*;
    typedef struct packed {
        logic [7:0] p, ttl;
        logic mf;
        logic [12:0] off;
        logic opt;
        logic [31:0] sa, da;
        logic [7:0] ty, cd;
    } eacm_tb_frm_t;
    localparam logic [31:0] ADDR_A = 32'hc0a80a01;
    localparam logic [31:0] MASK_A = 32'hffffff00;
    localparam logic [7:0] PV [5] = '{IPP_ICMP, IPP_TCP, IPP_UDP, 8'hff, 8'hfe};
    logic hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, rd, x;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [1:0] tm [3];
    wire logic hreadyout, hresp, hit_valid, hit, frm_valid, frm_more_fragments_bit, frm_options;
    wire logic [31:0] hrdata, frm_source_ip_address, frm_destination_ip_address;
    wire logic [7:0] frm_protocol, frm_ttl, frm_icmp_type, frm_icmp_code;
    wire logic [12:0] frm_fragment_offset_field;
    int errors, checks, exp_cnt;
    eacm_tb_frm_t base, f;

    eacm_ipv4_entry eacm_ipv4_entry_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .frm_valid,
        .frm_protocol, .frm_ttl, .frm_more_fragments_bit, .frm_fragment_offset_field,
        .frm_options, .frm_source_ip_address, .frm_destination_ip_address, .frm_icmp_type,
        .frm_icmp_code, .hit_valid, .hit);
    eacm_frame_src eacm_frame_src_inst (.hclk, .frm_valid, .frm_protocol, .frm_ttl,
        .frm_more_fragments_bit, .frm_fragment_offset_field, .frm_options,
        .frm_source_ip_address, .frm_destination_ip_address, .frm_icmp_type, .frm_icmp_code);

    function automatic logic tri_ok(input logic [1:0] m, input logic c);
        return (m == TRI_NO) ? !c : (m == TRI_YES) ? c : 1'b1;
    endfunction : tri_ok
    function automatic logic pr_ok(input logic [2:0] m, input logic [7:0] p);
        case (m)
            PR_SPEC: return p == 8'hff;
            PR_ICMP: return p == IPP_ICMP;
            PR_UDP: return p == IPP_UDP;
            PR_TCP: return p == IPP_TCP;
            default: return 1'b1;
        endcase
    endfunction : pr_ok
    function automatic logic [31:0] ctl(input logic [2:0] pr, input logic [1:0] t, fr, op, s,
        d, input logic it, ic);
        return {16'h0000, ic, it, d, s, op, fr, t, pr, 1'b1};
    endfunction : ctl

    task automatic finish_test();
        $display("Counts: %0d checks, %0d errors", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    // Samples ready half a cycle before each rising edge, as the master sees it at that edge
    task automatic wait_rdy();
        for (int n = 0; n < 40; n++) begin
            @(negedge hclk);
            if (hreadyout === 1'b1) return;
        end
        errors++;
        finish_test();
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        wait_rdy();
        @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        `CHECK(hresp, 1'b0)
        @(posedge hclk);
    endtask : bus
    task automatic frame(input logic e);
        eacm_frame_src_inst.send(f);
        @(negedge hclk);
        `CHECK(hit_valid, 1'b1)
        `CHECK(hit, e)
        exp_cnt += int'(e);
        @(posedge hclk);
    endtask : frame

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    initial begin
        errors = 0;
        checks = 0;
        exp_cnt = 0;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        base = '{IPP_UDP, 8'h40, 1'b0, 13'h0000, 1'b0, ADDR_A, ADDR_A, 8'hff, 8'hff};
        f = base;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, ending with one unmapped word
        for (int a = 0; a <= 32; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            `CHECK(rd, (a == 12 || a == 20) ? 32'hffffffff : 32'h00000000)
        end
        bus(1'b1, OFS_CTRL, ctl(PR_TCP, 0, 0, 0, 0, 0, 0, 0) ^ 32'h1);
        frame(1'b1);
        bus(1'b1, OFS_CTRL, ctl(PR_TCP, 0, 0, 0, 0, 0, 0, 0));
        frame(1'b0);
        bus(1'b1, OFS_VALS, 32'hffffffff);
        bus(1'b0, OFS_VALS, 32'h0);
        `CHECK(rd, 32'h00ffffff)
        bus(1'b1, OFS_SRC_ADDR, ADDR_A);
        bus(1'b1, OFS_SRC_MASK, MASK_A);
        bus(1'b0, OFS_SRC_MASK, 32'h0);
        `CHECK(rd, MASK_A)
        bus(1'b1, OFS_DST_ADDR, ADDR_A);
        bus(1'b1, OFS_DST_MASK, MASK_A);
        $display("test reset_and_frame_type done");
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, OFS_CTRL, ctl(3'(m), 0, 0, 0, 0, 0, 0, 0));
            for (int k = 0; k < 5; k++) begin
                f = base;
                f.p = PV[k];
                frame(pr_ok(3'(m), PV[k]));
            end
        end
        $display("test protocol done");
        for (int c = 0; c < 3; c++) begin
            for (int m = 0; m < 4; m++) begin
                tm = '{TRI_ANY, TRI_ANY, TRI_ANY};
                tm[c] = 2'(m);
                bus(1'b1, OFS_CTRL, ctl(PR_ANY, tm[0], tm[1], tm[2], 0, 0, 0, 0));
                for (int k = 0; k < 3; k++) begin
                    f = base;
                    f.ttl = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : 8'hff;
                    f.mf = (k == 1);
                    f.off = (k == 2) ? 13'h1fff : 13'h0000;
                    f.opt = (k != 0);
                    frame(tri_ok(2'(m), k != 0));
                end
            end
        end
        $display("test ttl_fragment_options done");
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 4; m++) begin
                bus(1'b1, OFS_CTRL, ctl(PR_ANY, 0, 0, 0, (s == 0) ? 2'(m) : AD_ANY,
                    (s == 1) ? 2'(m) : AD_ANY, 0, 0));
                for (int k = 0; k < 3; k++) begin
                    x = (k == 0) ? ADDR_A : (k == 1) ? (ADDR_A ^ 32'h1) : (ADDR_A ^ 32'h100);
                    f = base;
                    if (s == 0) f.sa = x;
                    if (s == 1) f.da = x;
                    frame(m == AD_HOST ? k == 0 :
                        m == AD_NET ? k != 2 : 1'b1);
                end
            end
        end
        $display("test addresses done");
        for (int u = 0; u < 2; u++) begin
            for (int m = 0; m < 4; m++) begin
                bus(1'b1, OFS_CTRL, ctl(u ? PR_UDP : PR_ICMP, 0, 0, 0, 0, 0, m[0], m[1]));
                for (int k = 0; k < 4; k++) begin
                    f = base;
                    f.p = u ? IPP_UDP : IPP_ICMP;
                    f.ty = k[0] ? 8'hfe : 8'hff;
                    f.cd = k[1] ? 8'h00 : 8'hff;
                    frame(u == 1 || !((m[0] && k[0]) || (m[1] && k[1])));
                end
            end
        end
        $display("test icmp done");
        bus(1'b1, OFS_CTRL, ctl(PR_UDP, TRI_YES, TRI_NO, TRI_NO, AD_NET, AD_HOST, 1, 1));
        f = base;
        frame(1'b1);
        f.da = ADDR_A ^ 32'h1;
        frame(1'b0);
        bus(1'b0, OFS_HIT_CNT, 32'h0);
        `CHECK(rd, 32'(exp_cnt))
        bus(1'b1, OFS_HIT_CNT, 32'h0);
        bus(1'b0, OFS_HIT_CNT, 32'h0);
        `CHECK(rd, 32'h00000000)
        // Status is read in the cycle the result stands; a hit beside a clear still counts
        f = base;
        fork
            bus(1'b0, OFS_STATUS, 32'h0);
            frame(1'b1);
        join
        `CHECK(rd, 32'h00000003)
        fork
            bus(1'b1, OFS_HIT_CNT, 32'h0);
            frame(1'b1);
        join
        bus(1'b0, OFS_HIT_CNT, 32'h0);
        `CHECK(rd, 32'h00000001)
        $display("test combined_and_count done");
        finish_test();
    end
endmodule : eacm_ipv4_entry_tb_top
`default_nettype wire
